/* File: src/ptm_pkg.sv */
/*
  Package for the 10-bit periodic timer: register offsets, field positions,
  reset values, mode and clock-select encodings.
  Assumes a byte-wide register port with registers at the indices below.
*/
package ptm_pkg;

  // ****************************************
  // register indices (byte port, one per address)
  // ****************************************
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] ADDR_PER_LO = 3'h6;
  localparam logic [2:0] ADDR_PER_HI = 3'h7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int C0_PAUSE = 7;
  localparam int C0_CKSEL_LSB = 4;
  localparam int C0_RUN = 3;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_PIN_LSB = 4;
  localparam int C1_INIT = 3;
  localparam int C1_INV = 2;
  localparam int C1_CLRSRC = 0;

  localparam logic [7:0] CTRL0_WMASK = 8'hF8;
  localparam logic [7:0] CTRL1_WMASK = 8'hFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CMP_RESET = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  localparam logic [1:0] PIN_NONE = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [1:0] PIN_TOGGLE = 2'h3;

  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CK_EXT_FALL = 3'h7;

  localparam int SYS_DIV = 4;
  localparam int HIGH_DIV_A = 16;
  localparam int HIGH_DIV_B = 64;

  typedef enum logic [2:0] {
    PTM_OUT_IDLE = 3'b001,
    PTM_OUT_ACTIVE = 3'b010,
    PTM_OUT_DONE = 3'b100
  } ptm_pulse_type;

endpackage : ptm_pkg

/* File: src/ptm_tick_if.sv */
/*
  Interface carrying the count tick from the clock selector to the timer core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface ptm_tick_if;
  logic [2:0] sel;
  logic tick;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface : ptm_tick_if

/* File: src/ptm_clk_sel.sv */
/*
  Count-clock selector: turns the chosen source into one-cycle ticks on clk_sys.
  Assumes high_clock and sub_clock are slow level inputs from other domains and
  that the external pin is slower than a third of clk_sys.
*/
`timescale 1ns/1ps
module ptm_clk_sel (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic high_clock,
  input wire logic sub_clock,
  input wire logic external_count_input,
  ptm_tick_if.src tk
);

  // ****************************************
  // three-stage synchronisers
  // ****************************************
  logic [2:0] ext_sync_reg;
  logic [2:0] high_sync_reg;
  logic [2:0] sub_sync_reg;
  logic [1:0] sys_div_reg;
  logic [5:0] high_div_reg;

  // a change counts only when stages two and three differ
  function automatic logic rise_f(input logic [2:0] s);
    rise_f = s[1] & ~s[2];
  endfunction : rise_f

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_reg <= 3'h0;
      high_sync_reg <= 3'h0;
      sub_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_count_input};
      high_sync_reg <= {high_sync_reg[1:0], high_clock};
      sub_sync_reg <= {sub_sync_reg[1:0], sub_clock};
    end
  end

  // ****************************************
  // dividers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_div_reg <= 2'h0;
    end else begin
      sys_div_reg <= sys_div_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      high_div_reg <= 6'h00;
    end else if (rise_f(high_sync_reg)) begin
      high_div_reg <= high_div_reg + 6'h01;
    end
  end

  always_comb begin
    case (tk.sel)
      ptm_pkg::CK_SYS4: tk.tick = (sys_div_reg == 2'(ptm_pkg::SYS_DIV - 1));
      ptm_pkg::CK_SYS: tk.tick = 1'b1;
      ptm_pkg::CK_H16: tk.tick = rise_f(high_sync_reg)
        && (high_div_reg[3:0] == 4'(ptm_pkg::HIGH_DIV_A - 1));
      ptm_pkg::CK_H64: tk.tick = rise_f(high_sync_reg)
        && (high_div_reg == 6'(ptm_pkg::HIGH_DIV_B - 1));
      ptm_pkg::CK_SUB0, ptm_pkg::CK_SUB1: tk.tick = rise_f(sub_sync_reg);
      ptm_pkg::CK_EXT_RISE: tk.tick = rise_f(ext_sync_reg);
      ptm_pkg::CK_EXT_FALL: tk.tick = ext_sync_reg[2] & ~ext_sync_reg[1];
      default: tk.tick = 1'b0;
    endcase
  end

endmodule : ptm_clk_sel

/* File: src/ptm_timer.sv */
/*
  10-bit periodic timer top: register port, up-counter, comparators A and P,
  output pin logic for compare-match, PWM and single-pulse modes.
  Assumes a byte register port, one clock clk_sys, external pins asynchronous.
*/
`timescale 1ns/1ps
module ptm_timer #(
  parameter int CNT_W = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic high_clock,
  input wire logic sub_clock,
  input wire logic external_count_input,
  output logic timer_output_pin,
  output logic timer_output_oe,
  output logic match_a_flag,
  output logic match_p_flag,
  output logic timer_request
);

  // the register pairs and hi_byte_f are laid out for ten bits only
  if (CNT_W != 10) begin : g_width_check
    $error("ptm_timer supports a counter width of 10 only");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [CNT_W-1:0] cmp_a_reg;
  logic [CNT_W-1:0] per_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic run_d_reg;
  logic pin_reg;
  logic run_clear_pulse;
  ptm_pkg::ptm_pulse_type pulse_state_reg;
  ptm_tick_if tk ();

  logic count_pause;
  logic [2:0] clock_source_select;
  logic timer_run;
  logic [1:0] operating_mode_select;
  logic [1:0] pin_action_select;
  logic output_initial_level;
  logic output_invert;
  logic clear_source_select;
  logic run_rise;
  logic match_a;
  logic match_p;
  logic overflow;
  logic cnt_clear;
  logic pwm_level;
  logic pulse_end;
  logic raw_level;
  logic pulse_mode;

  assign count_pause = ctrl0_reg[ptm_pkg::C0_PAUSE];
  assign clock_source_select = ctrl0_reg[ptm_pkg::C0_CKSEL_LSB +: 3];
  assign timer_run = ctrl0_reg[ptm_pkg::C0_RUN];
  assign operating_mode_select = ctrl1_reg[ptm_pkg::C1_MODE_LSB +: 2];
  assign pin_action_select = ctrl1_reg[ptm_pkg::C1_PIN_LSB +: 2];
  assign output_initial_level = ctrl1_reg[ptm_pkg::C1_INIT];
  assign output_invert = ctrl1_reg[ptm_pkg::C1_INV];
  assign clear_source_select = ctrl1_reg[ptm_pkg::C1_CLRSRC];
  assign run_rise = timer_run & ~run_d_reg;
  assign pulse_mode = (operating_mode_select == ptm_pkg::MODE_PWM)
    && (pin_action_select == ptm_pkg::PIN_TOGGLE);

  function automatic logic [7:0] hi_byte_f(input logic [CNT_W-1:0] v);
    hi_byte_f = {6'h00, v[9:8]};
  endfunction : hi_byte_f

  // ****************************************
  // count tick source
  // ****************************************
  assign tk.sel = clock_source_select;

  ptm_clk_sel u_clk_sel (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .high_clock(high_clock),
    .sub_clock(sub_clock),
    .external_count_input(external_count_input),
    .tk(tk.src)
  );

  // ****************************************
  // register writes
  // ****************************************
  // a single pulse ends by clearing run itself; a software write to CTRL0
  // in the same cycle wins over that hardware clear
  assign pulse_end = (operating_mode_select == ptm_pkg::MODE_PWM)
    && (pin_action_select == ptm_pkg::PIN_TOGGLE) && timer_run && match_a;
  assign run_clear_pulse = pulse_end;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_reg <= ptm_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == ptm_pkg::ADDR_CTRL0) begin
      ctrl0_reg <= reg_wdata & ptm_pkg::CTRL0_WMASK;
    end else if (run_clear_pulse) begin
      ctrl0_reg[ptm_pkg::C0_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_reg <= ptm_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == ptm_pkg::ADDR_CTRL1) begin
      // reserved bit 1 is stored as written; software keeps it zero
      ctrl1_reg <= reg_wdata & ptm_pkg::CTRL1_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_a_reg <= ptm_pkg::CMP_RESET;
      per_reg <= ptm_pkg::CMP_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ptm_pkg::ADDR_CMPA_LO: cmp_a_reg[7:0] <= reg_wdata;
        ptm_pkg::ADDR_CMPA_HI: cmp_a_reg[9:8] <= reg_wdata[1:0];
        ptm_pkg::ADDR_PER_LO: per_reg[7:0] <= reg_wdata;
        ptm_pkg::ADDR_PER_HI: per_reg[9:8] <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // register reads, data one cycle after strobe
  // ****************************************
  // data fall back to zero outside the answer cycle so no stale byte lingers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ptm_pkg::ADDR_CTRL0: reg_rdata <= ctrl0_reg;
        ptm_pkg::ADDR_CTRL1: reg_rdata <= ctrl1_reg;
        ptm_pkg::ADDR_CNT_LO: reg_rdata <= cnt_reg[7:0];
        ptm_pkg::ADDR_CNT_HI: reg_rdata <= hi_byte_f(cnt_reg);
        ptm_pkg::ADDR_CMPA_LO: reg_rdata <= cmp_a_reg[7:0];
        ptm_pkg::ADDR_CMPA_HI: reg_rdata <= hi_byte_f(cmp_a_reg);
        ptm_pkg::ADDR_PER_LO: reg_rdata <= per_reg[7:0];
        ptm_pkg::ADDR_PER_HI: reg_rdata <= hi_byte_f(per_reg);
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // comparators and clear selection
  // ****************************************
  // matches only count on a tick, so each event is a single cycle
  // matching on count+1 clears on the very tick that would reach the value
  assign match_a = tk.tick && timer_run && !count_pause
    && (cmp_a_reg != ptm_pkg::CMP_RESET) && (cnt_reg + 10'h001 == cmp_a_reg);
  assign match_p = tk.tick && timer_run && !count_pause
    && (per_reg != ptm_pkg::CMP_RESET) && (cnt_reg + 10'h001 == per_reg);
  assign overflow = tk.tick && timer_run && !count_pause
    && (cnt_reg == ptm_pkg::CNT_MAX);

  always_comb begin
    if (pulse_mode) begin
      // the period compare plays no part in a single pulse; only A ends it
      cnt_clear = overflow;
    end else if (operating_mode_select == ptm_pkg::MODE_PWM) begin
      // period value sets the cycle; zero lets it wrap at 1024
      cnt_clear = match_p || overflow;
    end else if (clear_source_select) begin
      cnt_clear = match_a || overflow;
    end else begin
      cnt_clear = match_p || overflow;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // run edge comes from a registered copy, so a held run bit starts only once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= timer_run;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 10'h000;
    end else if (run_rise) begin
      cnt_reg <= 10'h000;
    end else if (!timer_run || count_pause) begin
      cnt_reg <= cnt_reg;
    end else if (tk.tick) begin
      if (pulse_end) begin
        // a finished pulse parks the counter on the A value
        cnt_reg <= cmp_a_reg;
      end else if (cnt_clear) begin
        cnt_reg <= 10'h000;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end

  // ****************************************
  // match flags and request
  // ****************************************
  // flags are one-cycle pulses; a collector outside the block latches them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      timer_request <= 1'b0;
    end else begin
      match_a_flag <= match_a;
      match_p_flag <= match_p && (operating_mode_select == ptm_pkg::MODE_PWM
        || !clear_source_select);
      timer_request <= match_a || cnt_clear;
    end
  end

  // ****************************************
  // output pin
  // ****************************************
  // pwm active while count is below duty; duty at or above period is full on
  // a duty of zero keeps the pin inactive for the whole period
  always_comb begin
    if (cmp_a_reg == ptm_pkg::CMP_RESET) begin
      pwm_level = 1'b0;
    end else if (per_reg != ptm_pkg::CMP_RESET && cmp_a_reg >= per_reg) begin
      pwm_level = 1'b1;
    end else begin
      pwm_level = (cnt_reg < cmp_a_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg <= 1'b0;
    end else if (run_rise) begin
      pin_reg <= output_initial_level;
    end else if (operating_mode_select == ptm_pkg::MODE_CMP && match_a) begin
      case (pin_action_select)
        ptm_pkg::PIN_LOW: pin_reg <= 1'b0;
        ptm_pkg::PIN_HIGH: pin_reg <= 1'b1;
        ptm_pkg::PIN_TOGGLE: pin_reg <= ~pin_reg;
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  // the pulse state follows run in every mode, so a pulse selected while run is held
  // starts in the active state, and after a stop from the finished state until run rises again
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulse_state_reg <= ptm_pkg::PTM_OUT_IDLE;
    end else begin
      case (pulse_state_reg)
        ptm_pkg::PTM_OUT_IDLE: if (run_rise) pulse_state_reg <= ptm_pkg::PTM_OUT_ACTIVE;
        ptm_pkg::PTM_OUT_ACTIVE: if (!timer_run || pulse_end) begin
          pulse_state_reg <= ptm_pkg::PTM_OUT_DONE;
        end
        ptm_pkg::PTM_OUT_DONE: if (run_rise) pulse_state_reg <= ptm_pkg::PTM_OUT_ACTIVE;
        default: pulse_state_reg <= ptm_pkg::PTM_OUT_IDLE;
      endcase
    end
  end

  always_comb begin
    if (operating_mode_select == ptm_pkg::MODE_PWM) begin
      case (pin_action_select)
        ptm_pkg::PIN_NONE: raw_level = ~output_initial_level;
        ptm_pkg::PIN_LOW: raw_level = output_initial_level;
        ptm_pkg::PIN_HIGH: raw_level = pwm_level ? output_initial_level : ~output_initial_level;
        default: raw_level = (pulse_state_reg == ptm_pkg::PTM_OUT_ACTIVE)
          ? output_initial_level : ~output_initial_level;
      endcase
    end else begin
      raw_level = pin_reg;
    end
  end

  // the pin is only driven while the timer is in an output mode
  // modes 01 and 11 leave the pad to its other functions
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      timer_output_pin <= 1'b0;
      timer_output_oe <= 1'b0;
    end else begin
      // inversion is left out in timer mode, where the pin is not ours
      timer_output_pin <= raw_level
        ^ (output_invert && operating_mode_select != ptm_pkg::MODE_TMR);
      timer_output_oe <= (operating_mode_select == ptm_pkg::MODE_CMP)
        || (operating_mode_select == ptm_pkg::MODE_PWM);
    end
  end

endmodule : ptm_timer

/* File: bench/ptm_timer_props.sv */
/*
  Checker for the periodic timer top: port-level timing relations.
  Assumes the byte register port of ptm_pkg and the single clock clk_sys.
*/
`timescale 1ns/1ps
module ptm_timer_props #(
  parameter int CNT_W = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_output_pin,
  input wire logic timer_output_oe,
  input wire logic match_a_flag,
  input wire logic match_p_flag,
  input wire logic timer_request
);
  // ****
  // shadow state
  // ****
  logic [7:0] c0_reg;
  logic [7:0] c1_reg;
  logic [CNT_W-1:0] cmpa_reg;
  logic [2:0] quiet_reg;
  logic settled;
  logic [1:0] mode;
  // rebuilt from bus writes only; the hardware clear of run in pulse mode is not seen
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      cmpa_reg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ptm_pkg::ADDR_CTRL0) c0_reg <= reg_wdata;
      if (reg_addr == ptm_pkg::ADDR_CTRL1) c1_reg <= reg_wdata;
      if (reg_addr == ptm_pkg::ADDR_CMPA_LO) cmpa_reg[7:0] <= reg_wdata;
      if (reg_addr == ptm_pkg::ADDR_CMPA_HI) cmpa_reg[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end
  end
  // events already in the pipe when a write lands are let through
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) quiet_reg <= 3'h0;
    else if (reg_wr) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end
  assign settled = quiet_reg >= 3'h4;
  assign mode = c1_reg[7:6];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence run_start_s;
    reg_wr && reg_addr == ptm_pkg::ADDR_CTRL0 && reg_wdata[3] && !c0_reg[3] && mode == 2'h0;
  endsequence
  sequence hi_read_s;
    reg_rd && reg_addr[0] && reg_addr != ptm_pkg::ADDR_CTRL1;
  endsequence
  // ****
  // properties
  // ****
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero when idle");
  AST_HI_BYTE: assert property (
    hi_read_s |=> reg_rdata[7:2] == 6'h00) else $error("high byte upper bits set");
  AST_REQ_ON_A: assert property (
    match_a_flag |-> timer_request) else $error("A match without request");
  AST_NO_P_CLR_A: assert property (
    settled && c1_reg[0] && mode != 2'h2 |-> !match_p_flag) else $error("P flag with clear on A");
  AST_OE_MODE: assert property (
    settled |-> timer_output_oe == (mode == 2'h0 || mode == 2'h2)) else $error("oe wrong for mode");
  AST_PIN_INIT: assert property (
    run_start_s |-> ##3 timer_output_pin == (c1_reg[3] ^ c1_reg[2]))
    else $error("pin not at initial level after run start");
  AST_A_ZERO: assert property (
    settled && cmpa_reg == '0 && mode != 2'h2 |-> !match_a_flag) else $error("A flag with A zero");
  AST_HELD: assert property (
    settled && (!c0_reg[3] || c0_reg[7]) |-> !match_a_flag && !match_p_flag)
    else $error("match while stopped or paused");
  AST_P_NO_PIN: assert property (
    settled && match_p_flag && !match_a_flag && mode == 2'h0 |=> $stable(timer_output_pin))
    else $error("pin moved on P match");
endmodule : ptm_timer_props

/* File: bench/ptm_ext_model.sv */
/*
  Far-side model: drives the external count pin, counts output pin high cycles.
  Assumes pulses() is called by one process at a time.
*/
`timescale 1ns/1ps
module ptm_ext_model (
  input wire logic clk_sys,
  input wire logic pin,
  input wire logic oe,
  output logic ext_pin
);
  int hi_cnt = 0;
  initial ext_pin = 1'b0;
  // 4 high, 4 low: slow enough that the three-flop sync never merges edges
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : pulses
  always @(posedge clk_sys) begin
    if (oe === 1'b1 && pin === 1'b1) hi_cnt <= hi_cnt + 1;
  end
endmodule : ptm_ext_model

/* File: bench/ptm_timer_tb.sv */
/*
  Testbench for the periodic timer: register tasks and directed tests.
  Assumes ptm_ext_model on the pins and the checker bound below.
*/
`timescale 1ns/1ps
module ptm_timer_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic high_clock = 1'b0;
  logic sub_clock = 1'b0;
  logic ext_pin;
  logic pin;
  logic oe;
  logic flag_a;
  logic flag_p;
  logic req;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rv;
  logic [7:0] v1;
  int t1;
  int t2;
  int h0;
  int cnt;
  int tol;
  logic [3:0] init_t = 4'b0011;
  logic [3:0] after_t = 4'b1101;
  logic [7:0] rb_t [4] = '{8'hA5, 8'h02, 8'h5A, 8'h03};
  int ck_exp [8] = '{128, 513, 8, 2, 64, 64, 10, 10};
  int pw_c1 [6] = '{8'hA8, 8'hAC, 8'hA8, 8'h88, 8'h98, 8'hA8};
  int pw_p [6] = '{8, 8, 8, 8, 8, 0};
  int pw_a [6] = '{3, 3, 8, 3, 3, 256};
  int pw_w [6] = '{64, 64, 64, 64, 64, 1024};
  int pw_e [6] = '{24, 40, 64, 0, 64, 256};
  ptm_timer uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .high_clock(high_clock), .sub_clock(sub_clock), .external_count_input(ext_pin),
    .timer_output_pin(pin), .timer_output_oe(oe), .match_a_flag(flag_a),
    .match_p_flag(flag_p), .timer_request(req));
  ptm_ext_model ext (.clk_sys(clk_sys), .pin(pin), .oe(oe), .ext_pin(ext_pin));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    high_clock <= cyc[1];
    sub_clock <= cyc[2];
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd
  task automatic wr10(input logic [2:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 3'h1, {6'h00, v[9:8]});
  endtask : wr10
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wr(ptm_pkg::ADDR_CTRL0, 8'h10);
    wr10(ptm_pkg::ADDR_CMPA_LO, a);
    wr10(ptm_pkg::ADDR_PER_LO, p);
    wr(ptm_pkg::ADDR_CTRL1, c1);
  endtask : cfg
  task automatic wait_flag(input bit p, output int t);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (k < 3000 && (p ? flag_p : flag_a) !== 1'b1);
    t = cyc;
    if (k == 3000) chk("flag wait", 10'h001, 10'h000);
  endtask : wait_flag
  // ****
  // tests
  // ****
  initial begin : main
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0]);
      chk("reset value", 10'h000, {2'b00, rv});
    end
    wr10(ptm_pkg::ADDR_CMPA_LO, 10'h2A5);
    wr10(ptm_pkg::ADDR_PER_LO, 10'h35A);
    wr(ptm_pkg::ADDR_CMPA_HI, 8'hFE);
    for (int i = 0; i < 4; i++) begin
      rd(3'h4 + i[2:0]);
      chk("compare readback", {2'b00, rb_t[i]}, {2'b00, rv});
    end
    wr(ptm_pkg::ADDR_CNT_LO, 8'hFF);
    rd(ptm_pkg::ADDR_CNT_LO);
    chk("counter write", 10'h000, {2'b00, rv});
    wr(ptm_pkg::ADDR_CTRL0, 8'hF7);
    rd(ptm_pkg::ADDR_CTRL0);
    chk("ctrl0 readback", 10'h0F0, {2'b00, rv});
    wr(ptm_pkg::ADDR_CTRL1, 8'h40);
    repeat (2) @(posedge clk_sys);
    #1 chk("oe in mode 01", 10'h000, 10'(oe));
    $display("test registers done");
    for (int a = 0; a < 4; a++) begin
      cfg({2'b00, a[1:0], init_t[a], 3'b001}, 10'd5, 10'd0);
      wr(ptm_pkg::ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge clk_sys);
      #1 chk("start level", 10'(init_t[a]), 10'(pin));
      chk("oe in mode 00", 10'h001, 10'(oe));
      wait_flag(1'b0, t1);
      repeat (2) @(posedge clk_sys);
      #1 chk("match level", 10'(after_t[a]), 10'(pin));
    end
    wait_flag(1'b0, t1);
    wait_flag(1'b0, t2);
    chk("a period", 10'd5, 10'(t2 - t1));
    cfg(8'h30, 10'd3, 10'd8);
    wr(ptm_pkg::ADDR_CTRL0, 8'h18);
    wait_flag(1'b1, t1);
    wait_flag(1'b1, t2);
    chk("p period", 10'd8, 10'(t2 - t1));
    wait_flag(1'b0, t1);
    wait_flag(1'b0, t2);
    chk("a period clr p", 10'd8, 10'(t2 - t1));
    $display("test compare done");
    cfg(8'hC0, 10'd0, 10'd0);
    wr(ptm_pkg::ADDR_CTRL0, 8'h18);
    repeat (30) @(posedge clk_sys);
    wr(ptm_pkg::ADDR_CTRL0, 8'h98);
    rd(ptm_pkg::ADDR_CNT_LO);
    v1 = rv;
    repeat (20) @(posedge clk_sys);
    rd(ptm_pkg::ADDR_CNT_LO);
    chk("paused", {2'b00, v1}, {2'b00, rv});
    wr(ptm_pkg::ADDR_CTRL0, 8'h18);
    repeat (10) @(posedge clk_sys);
    rd(ptm_pkg::ADDR_CNT_LO);
    chk("resumed", 10'h001, 10'(rv > v1 && rv < v1 + 8'd20));
    wr(ptm_pkg::ADDR_CTRL0, 8'h10);
    rd(ptm_pkg::ADDR_CNT_LO);
    v1 = rv;
    repeat (20) @(posedge clk_sys);
    rd(ptm_pkg::ADDR_CNT_LO);
    chk("stopped", {2'b00, v1}, {2'b00, rv});
    wr(ptm_pkg::ADDR_CTRL0, 8'h18);
    rd(ptm_pkg::ADDR_CNT_LO);
    chk("restart", 10'h001, 10'(rv < 8'd8));
    $display("test run control done");
    for (int s = 0; s < 8; s++) begin
      wr(ptm_pkg::ADDR_CTRL0, {1'b0, s[2:0], 4'h0});
      wr(ptm_pkg::ADDR_CTRL0, {1'b0, s[2:0], 4'h8});
      if (s >= 6) ext.pulses(10);
      repeat ((s >= 6) ? 6 : 512) @(posedge clk_sys);
      wr(ptm_pkg::ADDR_CTRL0, {1'b0, s[2:0], 4'h0});
      rd(ptm_pkg::ADDR_CNT_LO);
      v1 = rv;
      rd(ptm_pkg::ADDR_CNT_HI);
      cnt = {rv[1:0], v1};
      tol = (s >= 6) ? 0 : 2;
      cnt = int'(cnt + tol >= ck_exp[s] && cnt <= ck_exp[s] + tol);
      chk("tick count", 10'h001, 10'(cnt));
    end
    $display("test clock select done");
    for (int i = 0; i < 6; i++) begin
      cfg(pw_c1[i][7:0], 10'(pw_a[i]), 10'(pw_p[i]));
      wr(ptm_pkg::ADDR_CTRL0, 8'h18);
      repeat (20) @(posedge clk_sys);
      h0 = ext.hi_cnt;
      repeat (pw_w[i]) @(posedge clk_sys);
      chk("pwm high", 10'(pw_e[i]), 10'(ext.hi_cnt - h0));
    end
    $display("test pwm done");
    cfg(8'hB8, 10'd20, 10'd0);
    wr(ptm_pkg::ADDR_CTRL0, 8'h18);
    h0 = ext.hi_cnt;
    repeat (60) @(posedge clk_sys);
    chk("pulse width", 10'h001, 10'(ext.hi_cnt - h0 >= 18 && ext.hi_cnt - h0 <= 21));
    rd(ptm_pkg::ADDR_CTRL0);
    chk("pulse run clear", 10'h010, {2'b00, rv});
    $display("test single pulse done");
    report_and_stop();
  end
endmodule : ptm_timer_tb
bind ptm_timer ptm_timer_props #(.CNT_W(CNT_W)) u_props (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .timer_output_pin(timer_output_pin),
  .timer_output_oe(timer_output_oe), .match_a_flag(match_a_flag),
  .match_p_flag(match_p_flag), .timer_request(timer_request));
